// *** logic/fre_pkg.sv ***
`default_nettype none

// ****************************************************************
// Shared constants and carrier types of the rounding block.
// ****************************************************************
package fre_pkg;

  // Width of the biased exponent field carried with each operation.
  localparam int EXP_W = 11;
  // Width of the kept significand, explicit integer bit included.
  localparam int MAN_W = 53;
  // Width of the register bus address.
  localparam int ADDR_W = 12;

  // Biased exponent code that encodes infinity and NaN.
  localparam logic [EXP_W-1:0] EXP_MAX = {EXP_W{1'b1}};
  // Exponent of the largest finite value.
  localparam logic [EXP_W-1:0] EXP_BIG = {{(EXP_W-1){1'b1}}, 1'b0};
  // Significand of infinity, integer bit only.
  localparam logic [MAN_W-1:0] MAN_INF = {1'b1, {(MAN_W-1){1'b0}}};
  // Significand of the quiet indefinite value.
  localparam logic [MAN_W-1:0] MAN_QNAN = {2'b11, {(MAN_W-2){1'b0}}};
  // Significand of the largest finite value.
  localparam logic [MAN_W-1:0] MAN_BIG = {MAN_W{1'b1}};

  // Byte offsets of the three registers.
  localparam logic [ADDR_W-1:0] OFS_STK_CTL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STK_STAT = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_SIMD_CSR = 12'h008;

  // Field positions inside the registers.
  localparam int STK_RSEL_LO = 10;
  localparam int SIMD_RSEL_LO = 13;
  localparam int SIMD_MASK_LO = 7;
  localparam int FLAG_LO = 0;

  // Bit index of each exception class inside a flag or mask group.
  localparam int FL_INV = 0;
  localparam int FL_DEN = 1;
  localparam int FL_DIV = 2;
  localparam int FL_OVF = 3;
  localparam int FL_UNF = 4;
  localparam int FL_INX = 5;

  // Values after reset: all exceptions masked, nearest rounding.
  localparam logic [31:0] STK_CTL_RST = 32'h0000003f;
  localparam logic [31:0] STK_STAT_RST = 32'h00000000;
  localparam logic [31:0] SIMD_CSR_RST = 32'h00001f80;

  // Writable bits of each register; the rest read as zero.
  localparam logic [31:0] STK_CTL_WMASK = 32'h00000c3f;
  localparam logic [31:0] STK_STAT_WMASK = 32'h0000003f;
  localparam logic [31:0] SIMD_CSR_WMASK = 32'h00007fbf;

  // Rounding selector encodings.
  typedef enum logic [1:0] {
    RND_NEAR = 2'b00,
    RND_DOWN = 2'b01,
    RND_UP = 2'b10,
    RND_ZERO = 2'b11
  } fre_rnd_t;

  // Environment that executes an operation.
  typedef enum logic {ENV_STACK, ENV_SIMD} fre_env_t;

  // Class of operation as seen by the rounding stage.
  typedef enum logic [1:0] {OP_ARITH, OP_CMP, OP_TRUNC_CVT, OP_NAN} fre_kind_t;

  // Operation handed over by the pipeline.
  typedef struct packed {
    fre_env_t env;
    fre_kind_t kind;
    logic sign;
    logic [EXP_W-1:0] exp;
    logic [MAN_W-1:0] mant;
    logic guard;
    logic sticky;
    logic tiny;
    logic pre_inv;
    logic pre_den;
    logic pre_div;
  } fre_op_t;

  // Result handed back to the pipeline.
  typedef struct packed {
    logic sign;
    logic [EXP_W-1:0] exp;
    logic [MAN_W-1:0] mant;
  } fre_res_t;

endpackage

`default_nettype wire

// *** logic/fre_round_exc_ctl.sv ***
// Our own choices: register access over APB and the address map.

`timescale 1ns/1ps
`default_nettype none

module fre_round_exc_ctl (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [fre_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic OP_VALID,
  input wire fre_pkg::fre_op_t OP,
  output logic RES_VALID,
  output fre_pkg::fre_res_t RES,
  output logic [5:0] RES_FLAGS,
  output logic TRAP_REQ
);

  // ****************************************************************
  // State of the block
  // ****************************************************************

  // Every flip-flop of the block lives in this one record.
  typedef struct packed {
    logic [31:0] stk_ctl;
    logic [31:0] stk_stat;
    logic [31:0] simd_csr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic res_valid;
    fre_pkg::fre_res_t res;
    logic [5:0] res_flags;
    logic trap;
  } fre_state_t;

  // Registered state and its next value.
  fre_state_t s_q;
  fre_state_t s_d;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Widens the four byte strobes to a mask over the data word.
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // Applies a bus write to the writable bits of a register.
  function automatic logic [31:0] merge_write(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [31:0] m
  );
    return (old & ~m) | (wdata & m);
  endfunction

  // ****************************************************************
  // Selection of the controlling environment
  // ****************************************************************

  // Mask group and rounding selector of the executing environment.
  logic [5:0] mask_sel;
  logic [1:0] round_sel_env;
  // Selector actually handed to the rounder.
  logic [1:0] round_sel_eff;

  // Each environment obeys only its own selector and masks.
  always_comb begin
    if (OP.env == fre_pkg::ENV_STACK) begin
      mask_sel = s_q.stk_ctl[fre_pkg::FLAG_LO +: 6];
      round_sel_env = s_q.stk_ctl[fre_pkg::STK_RSEL_LO +: 2];
    end else begin
      mask_sel = s_q.simd_csr[fre_pkg::SIMD_MASK_LO +: 6];
      round_sel_env = s_q.simd_csr[fre_pkg::SIMD_RSEL_LO +: 2];
    end
    // Truncating conversions override whatever the selector holds.
    if (OP.kind == fre_pkg::OP_TRUNC_CVT) begin
      round_sel_eff = fre_pkg::RND_ZERO;
    end else begin
      round_sel_eff = round_sel_env;
    end
  end

  // ****************************************************************
  // Rounder
  // ****************************************************************

  // Significand after the increment, with its carry on top.
  logic [fre_pkg::MAN_W:0] mant_sum;
  // Exact result could not be encoded.
  logic rnd_inexact;

  // Chooses between the two bracketing values.
  fre_round_unit #(
    .MW(fre_pkg::MAN_W)
  ) u_round (
    .mode(round_sel_eff),
    .sign(OP.sign),
    .mant(OP.mant),
    .guard(OP.guard),
    .sticky(OP.sticky),
    .mant_sum(mant_sum),
    .inexact(rnd_inexact)
  );

  // ****************************************************************
  // Exception evaluation
  // ****************************************************************

  // Significand and exponent after renormalising a carry.
  logic [fre_pkg::MAN_W-1:0] mant_rnd;
  logic [fre_pkg::EXP_W:0] exp_rnd;
  // Conditions found before and after the arithmetic.
  logic [5:0] pre_cond;
  logic [5:0] post_cond;
  // Flags of the operation and whether any of them is unmasked.
  logic [5:0] op_flags;
  logic op_trap;
  // Result driven toward the pipeline.
  fre_pkg::fre_res_t op_res;
  // Rounded value reached the overflow threshold.
  logic ovf_hit;
  // Masked overflow keeps the largest finite value.
  logic keep_big;

  // Works out the delivered value and flags of one operation.
  always_comb begin
    // A carry out of the significand bumps the exponent by one.
    if (mant_sum[fre_pkg::MAN_W]) begin
      mant_rnd = mant_sum[fre_pkg::MAN_W:1];
    end else begin
      mant_rnd = mant_sum[fre_pkg::MAN_W-1:0];
    end
    exp_rnd = {1'b0, OP.exp} + {{fre_pkg::EXP_W{1'b0}}, mant_sum[fre_pkg::MAN_W]};
    ovf_hit = exp_rnd >= {1'b0, fre_pkg::EXP_MAX};
    // Conditions that the pipeline spotted on the operands.
    pre_cond = '0;
    pre_cond[fre_pkg::FL_INV] = OP.pre_inv;
    pre_cond[fre_pkg::FL_DEN] = OP.pre_den;
    pre_cond[fre_pkg::FL_DIV] = OP.pre_div;
    post_cond = '0;
    op_res.sign = OP.sign;
    op_res.exp = OP.exp;
    op_res.mant = OP.mant;
    // Overflow response picks infinity or the largest finite value.
    case (fre_pkg::fre_rnd_t'(round_sel_eff))
      fre_pkg::RND_DOWN: begin
        keep_big = ~OP.sign;
      end
      fre_pkg::RND_UP: begin
        keep_big = OP.sign;
      end
      fre_pkg::RND_ZERO: begin
        keep_big = 1'b1;
      end
      default: begin
        keep_big = 1'b0;
      end
    endcase
    if (|(pre_cond & ~mask_sel)) begin
      // Unmasked operand fault: no arithmetic, operands untouched.
      post_cond = '0;
    end else if (OP.pre_inv) begin
      // Masked invalid: the quiet indefinite value.
      op_res.sign = 1'b1;
      op_res.exp = fre_pkg::EXP_MAX;
      op_res.mant = fre_pkg::MAN_QNAN;
    end else if (OP.pre_div) begin
      // Masked divide by zero: infinity with the operand sign.
      op_res.exp = fre_pkg::EXP_MAX;
      op_res.mant = fre_pkg::MAN_INF;
    end else if (OP.kind == fre_pkg::OP_CMP || OP.kind == fre_pkg::OP_NAN) begin
      // Compares and NaN results pass through unrounded.
      post_cond = '0;
    end else begin
      // A masked denormal lets the arithmetic carry on here.
      post_cond[fre_pkg::FL_INX] = rnd_inexact;
      op_res.mant = mant_rnd;
      op_res.exp = exp_rnd[fre_pkg::EXP_W-1:0];
      if (ovf_hit) begin
        post_cond[fre_pkg::FL_OVF] = 1'b1;
        if (mask_sel[fre_pkg::FL_OVF]) begin
          // The masked overflow value is never the exact one.
          post_cond[fre_pkg::FL_INX] = 1'b1;
          op_res.exp = keep_big ? fre_pkg::EXP_BIG : fre_pkg::EXP_MAX;
          op_res.mant = keep_big ? fre_pkg::MAN_BIG : fre_pkg::MAN_INF;
        end
      end
      // Tiny results flag underflow; masked only when also inexact.
      if (mask_sel[fre_pkg::FL_UNF]) begin
        post_cond[fre_pkg::FL_UNF] = OP.tiny & rnd_inexact;
      end else begin
        post_cond[fre_pkg::FL_UNF] = OP.tiny;
      end
    end
    // Several masked conditions may stack up in one operation.
    op_flags = pre_cond | post_cond;
    op_trap = |(op_flags & ~mask_sel);
  end

  // ****************************************************************
  // Register bus decode
  // ****************************************************************

  // Bus strobes and decode of the current transfer.
  logic setup_ph;
  logic wr_take;
  logic [31:0] wmask;
  logic hit_ctl;
  logic hit_stat;
  logic hit_csr;

  // Decodes the address and marks the edge at which a write lands.
  always_comb begin
    setup_ph = PSEL & ~PENABLE & ~s_q.pready;
    wr_take = PSEL & PENABLE & s_q.pready & PWRITE & ~s_q.pslverr;
    wmask = lane_mask(PSTRB);
    hit_ctl = PADDR == fre_pkg::OFS_STK_CTL;
    hit_stat = PADDR == fre_pkg::OFS_STK_STAT;
    hit_csr = PADDR == fre_pkg::OFS_SIMD_CSR;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Flags that this cycle's operation raises in each environment.
  logic [5:0] set_stk;
  logic [5:0] set_simd;

  // Fills the next copy of the state record.
  always_comb begin
    s_d = s_q;
    set_stk = '0;
    set_simd = '0;
    // Register read and answer: the slave answers with no wait state.
    if (setup_ph) begin
      s_d.pready = 1'b1;
      s_d.pslverr = ~(hit_ctl | hit_stat | hit_csr);
      if (hit_ctl) begin
        s_d.prdata = s_q.stk_ctl;
      end else if (hit_stat) begin
        s_d.prdata = s_q.stk_stat;
      end else if (hit_csr) begin
        s_d.prdata = s_q.simd_csr;
      end else begin
        s_d.prdata = '0;
      end
    end else if (PSEL & PENABLE & s_q.pready) begin
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
    end
    // Writes land on the access edge, writable bits only.
    if (wr_take & hit_ctl) begin
      s_d.stk_ctl = merge_write(s_q.stk_ctl, PWDATA, wmask & fre_pkg::STK_CTL_WMASK);
    end
    if (wr_take & hit_stat) begin
      s_d.stk_stat = merge_write(s_q.stk_stat, PWDATA, wmask & fre_pkg::STK_STAT_WMASK);
    end
    if (wr_take & hit_csr) begin
      s_d.simd_csr = merge_write(s_q.simd_csr, PWDATA, wmask & fre_pkg::SIMD_CSR_WMASK);
    end
    // Flags go only to the environment that ran the operation.
    if (OP_VALID) begin
      if (OP.env == fre_pkg::ENV_STACK) begin
        set_stk = op_flags;
      end else begin
        set_simd = op_flags;
      end
    end
    // Sticky flags: a new event wins over a clearing write.
    s_d.stk_stat[fre_pkg::FLAG_LO +: 6] |= set_stk;
    s_d.simd_csr[fre_pkg::FLAG_LO +: 6] |= set_simd;
    // Result, flags and trap request of the completing operation.
    s_d.res_valid = OP_VALID;
    if (OP_VALID) begin
      s_d.res = op_res;
      s_d.res_flags = op_flags;
    end
    s_d.trap = OP_VALID & op_trap;
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Synchronous reset loads masked exceptions and nearest rounding.
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      s_q.stk_ctl <= fre_pkg::STK_CTL_RST;
      s_q.stk_stat <= fre_pkg::STK_STAT_RST;
      s_q.simd_csr <= fre_pkg::SIMD_CSR_RST;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata <= '0;
      s_q.res_valid <= 1'b0;
      s_q.res <= '0;
      s_q.res_flags <= '0;
      s_q.trap <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Every output is a field of the state register.
  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign RES_VALID = s_q.res_valid;
  assign RES = s_q.res;
  assign RES_FLAGS = s_q.res_flags;
  assign TRAP_REQ = s_q.trap;

endmodule

`default_nettype wire

// *** logic/fre_round_unit.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Picks one of the two values that bracket the exact result.
// ****************************************************************
module fre_round_unit #(
  parameter int MW = 53
) (
  input wire logic [1:0] mode,
  input wire logic sign,
  input wire logic [MW-1:0] mant,
  input wire logic guard,
  input wire logic sticky,
  output logic [MW:0] mant_sum,
  output logic inexact
);

  // Increment that selects the upper bracketing value.
  logic inc;

  // The lower candidate is the truncated significand and the upper
  // one is a single unit above it, so either choice stays within one
  // unit in the last place of the exact result.
  always_comb begin
    inexact = guard | sticky;
    case (fre_pkg::fre_rnd_t'(mode))
      fre_pkg::RND_NEAR: begin
        // Above the half point, or exactly on it with an odd lsb.
        inc = guard & (sticky | mant[0]);
      end
      fre_pkg::RND_DOWN: begin
        // Negative magnitudes grow toward minus infinity.
        inc = sign & inexact;
      end
      fre_pkg::RND_UP: begin
        // Positive magnitudes grow toward plus infinity.
        inc = ~sign & inexact;
      end
      default: begin
        // Truncation never grows the magnitude.
        inc = 1'b0;
      end
    endcase
    mant_sum = {1'b0, mant} + {{MW{1'b0}}, inc};
  end

endmodule

`default_nettype wire

// *** test/fre_pipe_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Pipeline side that hands operations to the rounding block.
// ****************************************************************
module fre_pipe_model (
  input wire logic MCLK,
  output logic OP_VALID,
  output fre_pkg::fre_op_t OP
);
  // The port is idle from time zero.
  initial begin
    OP_VALID = 1'b0;
    OP = '0;
  end

  // Issues one operation after an optional idle gap.
  // Once the valid pulse is over, the operand bits are inverted so that
  // a stale operand can never pass for a fresh one.
  task automatic issue(input fre_pkg::fre_op_t op, input int gap);
    repeat (gap) @(posedge MCLK);
    @(posedge MCLK);
    OP_VALID <= 1'b1;
    OP <= op;
    @(posedge MCLK);
    OP_VALID <= 1'b0;
    OP <= fre_pkg::fre_op_t'(~op);
  endtask
endmodule

`default_nettype wire

// *** test/fre_round_exc_ctl_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Checker of the operation and register bus ports.
// ****************************************************************
module fre_round_exc_ctl_sva (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic OP_VALID,
  input wire fre_pkg::fre_op_t OP,
  input wire logic RES_VALID,
  input wire fre_pkg::fre_res_t RES,
  input wire logic [5:0] RES_FLAGS,
  input wire logic TRAP_REQ
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  logic pre; // Any precondition fault on the operation.
  logic norm; // Result range is safe from overflow and underflow.
  logic [64:0] opv_q; // Operand value of the last cycle.
  logic [2:0] pre_q; // Precondition bits of the last cycle.
  assign pre = OP.pre_inv | OP.pre_den | OP.pre_div;
  assign norm = !OP.tiny && (OP.exp < fre_pkg::EXP_BIG);

  // Keeps the operand one cycle for comparison with the result.
  always_ff @(posedge MCLK) begin
    opv_q <= {OP.sign, OP.exp, OP.mant};
    pre_q <= {OP.pre_div, OP.pre_den, OP.pre_inv};
  end

  a_res_latency: assert property (RES_VALID == ($past(OP_VALID) && $past(RST_B)))
    else $error("result pulse not one cycle after operation");
  a_trap_paired: assert property (TRAP_REQ |-> RES_VALID && RES_FLAGS != 6'h00)
    else $error("trap without a flagged result");
  a_cmp_passes: assert property (OP_VALID && (OP.kind == fre_pkg::OP_CMP ||
    OP.kind == fre_pkg::OP_NAN) |=> RES == opv_q && RES_FLAGS == 6'h00)
    else $error("compare or nan result altered");
  a_exact_quiet: assert property (OP_VALID && OP.kind == fre_pkg::OP_ARITH &&
    !OP.guard && !OP.sticky && !pre && norm |=> RES == opv_q && RES_FLAGS == 6'h00)
    else $error("exact result altered or flagged");
  a_inexact_set: assert property (OP_VALID && !OP.kind[0] && (OP.guard || OP.sticky) &&
    !pre && norm |=> RES_FLAGS[fre_pkg::FL_INX])
    else $error("inexact result not flagged");
  a_pre_flags: assert property (OP_VALID && OP.kind == fre_pkg::OP_ARITH |=>
    RES_FLAGS[2:0] == pre_q)
    else $error("precondition flags wrong");
  a_trunc_chop: assert property (OP_VALID && OP.kind == fre_pkg::OP_TRUNC_CVT &&
    !pre && norm |=> RES == opv_q)
    else $error("truncating conversion rounded away from zero");
  a_bus_answer: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("bus answer not one access cycle");
  a_res_holds: assert property (!OP_VALID |=> $stable(RES) && $stable(RES_FLAGS))
    else $error("result changed without operation");

  c_trap: cover property (TRAP_REQ);
  c_trunc: cover property (OP_VALID && OP.kind == fre_pkg::OP_TRUNC_CVT);
  c_ovf: cover property (RES_VALID && RES_FLAGS[fre_pkg::FL_OVF]);
endmodule

bind fre_round_exc_ctl fre_round_exc_ctl_sva u_sva (.MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .OP_VALID(OP_VALID), .OP(OP), .RES_VALID(RES_VALID),
  .RES(RES), .RES_FLAGS(RES_FLAGS), .TRAP_REQ(TRAP_REQ));

`default_nettype wire

// *** test/test_fre_round_exc_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Self-checking bench of the rounding and exception block.
// ****************************************************************
module test_fre_round_exc_ctl;
  logic MCLK = 1'b0;
  logic RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, OP_VALID, RES_VALID, TRAP_REQ;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [5:0] RES_FLAGS;
  fre_pkg::fre_op_t OP, op;
  fre_pkg::fre_res_t RES;
  logic er, sg, g, s, tr, inc, big;
  logic [1:0] md;
  int i, c, m, error_cnt, total_checks;
  localparam logic [31:0] rst_v [3] = '{32'h3f, 32'h0, 32'h1f80}; // Values after reset.
  localparam logic [31:0] wr_v [3] = '{32'hc3f, 32'h3f, 32'h7fbf}; // Writable bits.
  localparam logic [52:0] inf = {1'b1, 52'h0}; // Integer bit only.

  // Clock of 8 ns.
  always #4 MCLK = ~MCLK;

  fre_round_exc_ctl dut (.MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hf), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .OP_VALID(OP_VALID), .OP(OP),
    .RES_VALID(RES_VALID), .RES(RES), .RES_FLAGS(RES_FLAGS), .TRAP_REQ(TRAP_REQ));

  fre_pipe_model u_pipe (.MCLK(MCLK), .OP_VALID(OP_VALID), .OP(OP));

  // Prints the counts and the verdict, then stops.
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compares one value with its expectation.
  task chk(input logic [71:0] got, input logic [71:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer; the request stands until ready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int k;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge MCLK);
      if (PREADY === 1'b1) break;
    end
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (k == 20) begin
      error_cnt++;
      end_of_test;
    end
  endtask

  // Issues an operation and waits for its result pulse.
  task run(input fre_pkg::fre_op_t o, input int gap);
    int k;
    u_pipe.issue(o, gap);
    for (k = 0; k < 20; k++) begin
      #1;
      if (RES_VALID === 1'b1) break;
      @(posedge MCLK);
    end
    if (k == 20) begin
      error_cnt++;
      end_of_test;
    end
  endtask

  // Runs an operation and checks trap, flags and result together.
  task oc(input fre_pkg::fre_op_t o, input int gap, input logic [64:0] r, input logic [6:0] ft);
    run(o, gap);
    chk({TRAP_REQ, RES_FLAGS, RES}, {ft, r});
  endtask

  // Builds an operation; bits are guard, sticky, tiny, invalid, denormal, divide.
  function automatic fre_pkg::fre_op_t mk(logic e, logic [1:0] k, logic sn, logic [10:0] x,
                                          logic [52:0] mt, logic [5:0] bits);
    return fre_pkg::fre_op_t'({e, k, sn, x, mt, bits});
  endfunction

  // Main sequence.
  initial begin
    RST_B = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = '0;
    PWDATA = '0;
    error_cnt = 0;
    total_checks = 0;
    repeat (10) @(posedge MCLK);
    RST_B <= 1'b1;
    // Reset values, then reserved bits after an all-ones write.
    for (i = 0; i < 3; i++) begin
      apb(1'b0, 12'(4 * i), '0, rd, er);
      chk(72'({er, rd}), 72'(rst_v[i]));
      apb(1'b1, 12'(4 * i), 32'hffffffff, rd, er);
      apb(1'b0, 12'(4 * i), '0, rd, er);
      chk(72'({er, rd}), 72'(wr_v[i]));
      apb(1'b1, 12'(4 * i), rst_v[i], rd, er);
    end
    // An unmapped address answers with an error and no data.
    apb(1'b0, 12'h00c, '0, rd, er);
    chk(72'({er, rd}), 72'({1'b1, 32'h0}));
    // Every selector, sign, tie and lsb; the two environments hold different modes.
    for (m = 0; m < 4; m++) begin
      apb(1'b1, 12'h000, 32'h3f | (m << 10), rd, er);
      apb(1'b1, 12'h008, 32'h1f80 | ((3 - m) << 13), rd, er);
      for (c = 0; c < 48; c++) begin
        sg = c[2];
        g = (c >> 4) > 0;
        s = (c >> 4) != 1;
        tr = c[0] & c[1];
        md = tr ? 2'b11 : (c[0] ? 2'(3 - m) : 2'(m));
        case (md)
          2'b00: inc = g & (s | c[3]);
          2'b01: inc = sg;
          2'b10: inc = !sg;
          default: inc = 1'b0;
        endcase
        op = mk(c[0], tr ? 2'd2 : 2'd0, sg, 11'h400, {1'b1, 51'h0, c[3]}, {g, s, 4'h0});
        oc(op, c % 2, {sg, 11'h400, op.mant + 53'(inc)},
           7'h20);
      end
    end
    // Compare and nan kinds pass unchanged.
    for (c = 1; c < 4; c += 2) begin
      oc(mk(1'b0, 2'(c), 1'b1, 11'h123, {1'b1, 52'h5}, 6'h20), 0,
         {1'b1, 11'h123, 1'b1, 52'h5}, 7'h0);
    end
    // Flags of both environments stay set, then the stack flags clear by writing zero.
    apb(1'b0, 12'h004, '0, rd, er);
    chk(72'(rd), 72'(32'h20));
    apb(1'b0, 12'h008, '0, rd, er);
    chk(72'(rd), 72'(32'h1fa0));
    apb(1'b1, 12'h004, '0, rd, er);
    apb(1'b1, 12'h008, 32'h1f80, rd, er);
    apb(1'b0, 12'h004, '0, rd, er);
    chk(72'(rd), 72'(32'h0));
    // Masked overflow: infinity or largest finite by mode and sign.
    for (c = 0; c < 8; c++) begin
      md = 2'(c >> 1);
      sg = c[0];
      apb(1'b1, 12'h000, 32'h3f | (md << 10), rd, er);
      big = md == 2'b11 || (md == 2'b01 && !sg) || (md == 2'b10 && sg);
      oc(mk(1'b0, 2'd0, sg, 11'h7ff, inf, 6'h20), 0,
         big ? {sg, 11'h7fe, {53{1'b1}}} : {sg, 11'h7ff, inf}, 7'h28);
    end
    apb(1'b1, 12'h000, 32'h3f, rd, er);
    // An exact result passes unflagged; a rounding carry bumps the exponent.
    oc(mk(1'b0, 2'd0, 1'b1, 11'h400, inf, 6'h00), 0, {1'b1, 11'h400, inf}, 7'h00);
    oc(mk(1'b0, 2'd0, 1'b0, 11'h400, {53{1'b1}}, 6'h30), 0,
       {1'b0, 11'h401, inf}, 7'h20);
    oc(mk(1'b0, 2'd0, 1'b0, 11'h400, inf, 6'h04), 0,
       {1'b1, 11'h7ff, 2'b11, 51'h0}, 7'h01);
    oc(mk(1'b0, 2'd0, 1'b1, 11'h400, inf, 6'h01), 0, {1'b1, 11'h7ff, inf}, 7'h04);
    run(mk(1'b0, 2'd0, 1'b0, 11'h001, inf, 6'h2a), 0);
    chk(72'(RES_FLAGS), 72'(6'h32));
    apb(1'b0, 12'h004, '0, rd, er);
    chk(72'(rd), 72'(32'h3f));
    // Unmasked conditions request a trap; the other environment stays masked.
    apb(1'b1, 12'h000, 32'h1f, rd, er);
    oc(mk(1'b0, 2'd0, 1'b0, 11'h400, inf, 6'h20), 1,
       {1'b0, 11'h400, inf}, 7'h60);
    apb(1'b1, 12'h000, 32'h3e, rd, er);
    oc(mk(1'b0, 2'd0, 1'b0, 11'h400, inf, 6'h24), 0,
       {1'b0, 11'h400, inf}, 7'h41);
    oc(mk(1'b1, 2'd0, 1'b0, 11'h400, inf, 6'h04), 0,
       {1'b1, 11'h7ff, 2'b11, 51'h0}, 7'h01);
    // Unmasked underflow traps on a tiny result even when exact.
    apb(1'b1, 12'h000, 32'h2f, rd, er);
    oc(mk(1'b0, 2'd0, 1'b0, 11'h001, inf, 6'h08), 0, {1'b0, 11'h001, inf}, 7'h50);
    end_of_test;
  end
endmodule

`default_nettype wire
